/* core/eeprom_link_pkg.sv */
package eeprom_link_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // control byte
    localparam logic [3:0] ARRAY_TYPE_ID = 4'ha;
    localparam logic [3:0] PROT_TYPE_ID = 4'h6;
    localparam logic [2:0] SET_LOCK_SELECT = 3'h1;
    localparam logic [2:0] CLEAR_LOCK_SELECT = 3'h3;
    localparam int ADDR_W = 8;
    localparam int ARRAY_BYTES = 256;
    localparam int BITS_PER_BYTE = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int LINK_PERIOD_NS = 80;
    localparam int WRITE_TIME_NS = 1000000;
    localparam int WRITE_CYCLES = WRITE_TIME_NS / LINK_PERIOD_NS;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_PERIOD_NS = 10000;
    localparam int QTR_CYCLES = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

    ////////////////////////////////////////////////////////////////////////////////
    // controller registers (word index on the bus)
    localparam logic [1:0] REG_CMD = 2'h0;
    localparam logic [1:0] REG_TXDATA = 2'h1;
    localparam logic [1:0] REG_STATUS = 2'h2;
    localparam int CMD_START_BIT = 0;
    localparam int CMD_STOP_BIT = 1;
    localparam int CMD_READ_BIT = 2;
    localparam int CMD_WRITE_BIT = 3;
    localparam int CMD_NACK_BIT = 4;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_ACK_BIT = 1;
    localparam int STATUS_RX_LSB = 8;
    localparam logic [7:0] TXDATA_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // state encodings
    typedef enum logic [2:0] {
        DEV_IDLE = 3'b000,
        DEV_CTRL = 3'b001,
        DEV_WADDR = 3'b010,
        DEV_WDATA = 3'b011,
        DEV_ACK = 3'b100,
        DEV_RDATA = 3'b101,
        DEV_RD_ACK = 3'b110,
        DEV_IGNORE = 3'b111
    } dev_state_e;

    typedef enum logic [1:0] {
        HOST_IDLE = 2'b00,
        HOST_START = 2'b01,
        HOST_BIT = 2'b10,
        HOST_STOP = 2'b11
    } host_state_e;

endpackage : eeprom_link_pkg

/* core/eeprom_link_if.sv */
`timescale 1ns/10ps
interface eeprom_link_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic sda;

    // open-drain wire with pull-up
    assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

    modport host (
        output scl,
        output host_sda_o,
        output host_sda_oe,
        input sda
    );

    modport device (
        input scl,
        input sda,
        output dev_sda_o,
        output dev_sda_oe
    );
endinterface : eeprom_link_if

/* core/eeprom_link_device.sv */
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
module eeprom_link_device
    import eeprom_link_pkg::*;
#(
    parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
    input wire logic link_clk,
    input wire logic rst,
    eeprom_link_if.device link,
    input wire logic select_pin_low,
    input wire logic select_pin_mid,
    input wire logic select_pin_high,
    input wire logic supply_low,
    input wire logic permanent_lower_lock,
    input wire logic resettable_lower_lock,
    output logic write_busy,
    output logic [ADDR_W-1:0] addr_ptr
);
    localparam int CNT_W = $clog2(WRITE_CYCLES_P + 1);

    logic [7:0] pin_meta_r;
    logic [7:0] pin_sync_r;
    logic scl_prev_r;
    logic sda_prev_r;
    logic scl_s;
    logic sda_s;
    logic [2:0] sel_s;
    logic supply_low_s;
    logic perm_lock_s;
    logic reset_lock_s;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    dev_state_e state_r;
    dev_state_e after_r;
    dev_state_e after_nxt;
    logic ack_nxt;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic sda_oe_r;
    logic [ADDR_W-1:0] ptr_r;
    logic wrote_r;
    logic busy_r;
    logic [CNT_W-1:0] wcnt_r;
    logic [7:0] mem [ARRAY_BYTES];
    logic cs_match;
    logic prot_ok;

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and line events
    always_ff @(posedge link_clk) begin
        if (rst) begin
            pin_meta_r <= 8'hc0;
            pin_sync_r <= 8'hc0;
        end else begin
            pin_meta_r <= {link.scl, link.sda, select_pin_high, select_pin_mid, select_pin_low,
                           supply_low, permanent_lower_lock, resettable_lower_lock};
            pin_sync_r <= pin_meta_r;
        end
    end

    assign scl_s = pin_sync_r[7];
    assign sda_s = pin_sync_r[6];
    assign sel_s = pin_sync_r[5:3];
    assign supply_low_s = pin_sync_r[2];
    assign perm_lock_s = pin_sync_r[1];
    assign reset_lock_s = pin_sync_r[0];

    always_ff @(posedge link_clk) begin
        if (rst) begin
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end else begin
            scl_prev_r <= scl_s;
            sda_prev_r <= sda_s;
        end
    end

    assign start_det = scl_s && scl_prev_r && sda_prev_r && !sda_s;
    assign stop_det = scl_s && scl_prev_r && !sda_prev_r && sda_s;
    assign scl_rise = scl_s && !scl_prev_r;
    assign scl_fall = !scl_s && scl_prev_r;

    ////////////////////////////////////////////////////////////////////////////////
    // acknowledge decision at the end of a received byte
    assign cs_match = (shift_r[3:1] == sel_s);
    always_comb begin
        if (perm_lock_s) begin
            prot_ok = 1'b0;
        end else if (shift_r[3:1] == SET_LOCK_SELECT) begin
            prot_ok = !reset_lock_s;
        end else begin
            prot_ok = (shift_r[3:1] == CLEAR_LOCK_SELECT) || cs_match;
        end
    end

    always_comb begin
        ack_nxt = 1'b0;
        after_nxt = DEV_IGNORE;
        case (state_r)
            DEV_CTRL: begin
                if (busy_r) begin
                    ack_nxt = 1'b0;
                end else if (shift_r[7:4] == ARRAY_TYPE_ID && cs_match) begin
                    ack_nxt = 1'b1;
                    after_nxt = shift_r[0] ? DEV_RDATA : DEV_WADDR;
                end else if (shift_r[7:4] == PROT_TYPE_ID) begin
                    ack_nxt = prot_ok;
                end
            end
            DEV_WADDR, DEV_WDATA: begin
                ack_nxt = 1'b1;
                after_nxt = DEV_WDATA;
            end
            default: begin
                ack_nxt = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // transfer engine
    always_ff @(posedge link_clk) begin
        if (rst) begin
            state_r <= DEV_IDLE;
            after_r <= DEV_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            sda_oe_r <= 1'b0;
            ptr_r <= '0;
            wrote_r <= 1'b0;
        end else if (start_det) begin
            state_r <= DEV_CTRL; // pointer already loaded
            bit_cnt_r <= 4'h0;
            sda_oe_r <= 1'b0;
            wrote_r <= 1'b0;
        end else if (stop_det) begin
            state_r <= DEV_IDLE;
            sda_oe_r <= 1'b0;
            wrote_r <= 1'b0;
        end else begin
            case (state_r)
                DEV_CTRL, DEV_WADDR, DEV_WDATA: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], sda_s};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (scl_fall && bit_cnt_r == 4'(BITS_PER_BYTE)) begin
                        bit_cnt_r <= 4'h0;
                        sda_oe_r <= ack_nxt;
                        after_r <= after_nxt;
                        state_r <= ack_nxt ? DEV_ACK : DEV_IGNORE;
                        if (state_r == DEV_WADDR) begin
                            ptr_r <= shift_r;
                        end
                        if (state_r == DEV_WDATA) begin
                            ptr_r <= ptr_r + 8'h01;
                            if (!supply_low_s) begin
                                wrote_r <= 1'b1;
                            end
                        end
                    end
                end
                DEV_ACK: begin
                    if (scl_fall) begin
                        state_r <= after_r;
                        sda_oe_r <= 1'b0;
                        if (after_r == DEV_RDATA) begin
                            shift_r <= mem[ptr_r];
                            sda_oe_r <= !mem[ptr_r][7];
                        end
                    end
                end
                DEV_RDATA: begin
                    if (scl_rise) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_r == 4'(BITS_PER_BYTE)) begin
                            bit_cnt_r <= 4'h0;
                            sda_oe_r <= 1'b0;
                            state_r <= DEV_RD_ACK;
                            ptr_r <= ptr_r + 8'h01;
                        end else begin
                            sda_oe_r <= !shift_r[6];
                            shift_r <= {shift_r[6:0], 1'b0};
                        end
                    end
                end
                DEV_RD_ACK: begin
                    if (scl_rise) begin
                        after_r <= DEV_RDATA;
                        state_r <= sda_s ? DEV_IGNORE : DEV_ACK;
                    end
                end
                default: begin
                    sda_oe_r <= 1'b0;
                end
            endcase
        end
    end

    // array write, gated by the supply detector
    always_ff @(posedge link_clk) begin
        if (!rst && !start_det && !stop_det && state_r == DEV_WDATA && scl_fall
            && bit_cnt_r == 4'(BITS_PER_BYTE) && !supply_low_s) begin
            mem[ptr_r] <= shift_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // self-timed write cycle
    always_ff @(posedge link_clk) begin
        if (rst) begin
            wcnt_r <= '0;
            busy_r <= 1'b0;
        end else if (stop_det && wrote_r && !supply_low_s) begin
            wcnt_r <= CNT_W'(WRITE_CYCLES_P);
            busy_r <= 1'b1;
        end else if (wcnt_r != '0) begin
            wcnt_r <= wcnt_r - 1'b1;
            busy_r <= (wcnt_r != CNT_W'(1));
        end
    end

    assign write_busy = busy_r;
    assign addr_ptr = ptr_r;
    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe = sda_oe_r;

endmodule : eeprom_link_device

/* core/eeprom_link_host.sv */
`timescale 1ns/10ps
module eeprom_link_host
    import eeprom_link_pkg::*;
#(
    parameter int QTR_P = QTR_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    eeprom_link_if.host link,
    input wire logic [1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest
);
    localparam int QW = $clog2(QTR_P + 1);

    logic wait_r;
    logic [31:0] readdata_r;
    logic [7:0] tx_r;
    logic [4:0] cmd_r;
    logic go;
    logic wr_take;
    host_state_e state_r;
    host_state_e after_start;
    logic [QW-1:0] qcnt_r;
    logic tick;
    logic [1:0] phase_r;
    logic [3:0] bit_r;
    logic [7:0] shift_r;
    logic ack_r;
    logic scl_r;
    logic sda_oe_r;
    logic sda_meta_r;
    logic sda_s;

    ////////////////////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle per access
    always_ff @(posedge clk) begin
        if (rst) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= !((read || write) && wait_r);
        end
    end

    assign wr_take = write && !wait_r;
    assign go = wr_take && address == REG_CMD && state_r == HOST_IDLE;

    always_ff @(posedge clk) begin
        if (rst) begin
            readdata_r <= 32'h0;
        end else if (read && wait_r) begin
            case (address)
                REG_TXDATA: readdata_r <= {24'h0, tx_r};
                REG_STATUS: readdata_r <= {16'h0, shift_r, 6'h0, ack_r, state_r != HOST_IDLE};
                default: readdata_r <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_r <= TXDATA_RESET;
            cmd_r <= 5'h0;
        end else begin
            if (wr_take && address == REG_TXDATA) begin
                tx_r <= writedata[7:0];
            end
            if (go) begin
                cmd_r <= writedata[4:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // quarter-bit timebase and line engine
    always_ff @(posedge clk) begin
        if (rst || state_r == HOST_IDLE || tick) begin
            qcnt_r <= '0;
        end else begin
            qcnt_r <= qcnt_r + 1'b1;
        end
    end

    assign tick = (qcnt_r == QW'(QTR_P - 1));

    always_ff @(posedge clk) begin
        if (rst) begin
            sda_meta_r <= 1'b1;
            sda_s <= 1'b1;
        end else begin
            sda_meta_r <= link.sda;
            sda_s <= sda_meta_r;
        end
    end

    always_comb begin
        if (cmd_r[CMD_READ_BIT] || cmd_r[CMD_WRITE_BIT]) begin
            after_start = HOST_BIT;
        end else if (cmd_r[CMD_STOP_BIT]) begin
            after_start = HOST_STOP;
        end else begin
            after_start = HOST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= HOST_IDLE;
            phase_r <= 2'h0;
            bit_r <= 4'h0;
            shift_r <= 8'h00;
            ack_r <= 1'b0;
            scl_r <= 1'b1;
            sda_oe_r <= 1'b0;
        end else if (go) begin
            phase_r <= 2'h0;
            bit_r <= 4'h0;
            shift_r <= writedata[CMD_WRITE_BIT] ? tx_r : 8'hff;
            if (writedata[CMD_START_BIT]) begin
                state_r <= HOST_START;
            end else if (writedata[CMD_READ_BIT] || writedata[CMD_WRITE_BIT]) begin
                state_r <= HOST_BIT;
            end else if (writedata[CMD_STOP_BIT]) begin
                state_r <= HOST_STOP;
            end
        end else if (tick) begin
            phase_r <= phase_r + 2'h1;
            case (state_r)
                HOST_START: begin
                    case (phase_r)
                        2'h0: sda_oe_r <= 1'b0;
                        2'h1: scl_r <= 1'b1;
                        2'h2: sda_oe_r <= 1'b1;
                        default: begin
                            scl_r <= 1'b0;
                            state_r <= after_start;
                        end
                    endcase
                end
                HOST_BIT: begin
                    case (phase_r)
                        2'h0: begin
                            if (bit_r != 4'(BITS_PER_BYTE)) begin
                                sda_oe_r <= cmd_r[CMD_WRITE_BIT] && !shift_r[7];
                            end else begin
                                sda_oe_r <= cmd_r[CMD_READ_BIT] && !cmd_r[CMD_NACK_BIT];
                            end
                        end
                        2'h1: scl_r <= 1'b1;
                        2'h2: begin
                            if (bit_r != 4'(BITS_PER_BYTE)) begin
                                shift_r <= {shift_r[6:0], sda_s};
                            end else begin
                                ack_r <= !sda_s;
                            end
                        end
                        default: begin
                            scl_r <= 1'b0;
                            bit_r <= bit_r + 4'h1;
                            if (bit_r == 4'(BITS_PER_BYTE)) begin
                                sda_oe_r <= 1'b0;
                                state_r <= cmd_r[CMD_STOP_BIT] ? HOST_STOP : HOST_IDLE;
                            end
                        end
                    endcase
                end
                HOST_STOP: begin
                    case (phase_r)
                        2'h0: sda_oe_r <= 1'b1;
                        2'h1: scl_r <= 1'b1;
                        2'h2: sda_oe_r <= 1'b0;
                        default: state_r <= HOST_IDLE;
                    endcase
                end
                default: phase_r <= 2'h0;
            endcase
        end
    end

    assign readdata = readdata_r;
    assign waitrequest = wait_r;
    assign link.scl = scl_r;
    assign link.host_sda_o = 1'b0;
    assign link.host_sda_oe = sda_oe_r;

endmodule : eeprom_link_host

/* testbench/eeprom_link_asserts.sv */
`timescale 1ns/10ps
module eeprom_link_asserts
    import eeprom_link_pkg::*;
#(
    parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
    input wire logic clk,
    input wire logic link_clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_oe,
    input wire logic write_busy,
    input wire logic [ADDR_W-1:0] addr_ptr,
    input wire logic supply_low,
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest
);
    localparam int BUSY_MAX = WRITE_CYCLES_P + 8;

    ////////////////////////////////////////////////////////////////////////////////
    // link side
    a_drive_scl_low: assert property (@(posedge link_clk) disable iff (rst)
        $changed(dev_sda_oe) |-> !scl) else $error("device sda drive changed while scl high");
    a_busy_no_ack: assert property (@(posedge link_clk) disable iff (rst)
        write_busy |-> !dev_sda_oe) else $error("device drove sda during write cycle");
    a_busy_span: assert property (@(posedge link_clk) disable iff (rst)
        $rose(write_busy) |-> write_busy [*8] ##[1:BUSY_MAX] !write_busy) else $error("write cycle length wrong");
    a_busy_on_stop: assert property (@(posedge link_clk) disable iff (rst)
        $rose(write_busy) |-> scl && sda) else $error("write cycle began without stop");
    a_low_supply_hold: assert property (@(posedge link_clk) disable iff (rst)
        $rose(write_busy) |-> !supply_low) else $error("write cycle began under low supply");
    a_ptr_step_one: assert property (@(posedge link_clk) disable iff (rst)
        $changed(addr_ptr) |-> (addr_ptr == 8'($past(addr_ptr) + 8'h01)) || dev_sda_oe)
        else $error("pointer moved by other than one");
    a_reset_clear: assert property (@(posedge link_clk) disable iff (rst)
        $fell(rst) |-> !write_busy && addr_ptr == 8'h00 && !dev_sda_oe) else $error("device not cleared by reset");

    ////////////////////////////////////////////////////////////////////////////////
    // register bus side
    a_bus_answer: assert property (@(posedge clk) disable iff (rst)
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest) else $error("bus answer timing wrong");
endmodule : eeprom_link_asserts

/* testbench/test_eeprom_i2c_read_and_poll.sv */
`timescale 1ns/10ps
module test_eeprom_i2c_read_and_poll;
    import eeprom_link_pkg::*;
    localparam int BUSY_CYC = 400;
    localparam logic [2:0] SEL = 3'h5;
    localparam logic [4:0] CS = 5'h01;
    localparam logic [4:0] CP = 5'h02;
    localparam logic [4:0] CR = 5'h04;
    localparam logic [4:0] CW = 5'h08;
    localparam logic [4:0] CN = 5'h10;
    localparam logic [7:0] CTLW = {ARRAY_TYPE_ID, SEL, 1'b0};
    localparam logic [7:0] CTLR = {ARRAY_TYPE_ID, SEL, 1'b1};
    logic clk, link_clk, rst, read, write, waitrequest, supply_low, write_busy;
    logic permanent_lower_lock, resettable_lower_lock;
    logic [1:0] address;
    logic [31:0] writedata, readdata;
    logic [ADDR_W-1:0] addr_ptr;
    int bad_count, checks;

    eeprom_link_if link();
    eeprom_link_host #(.QTR_P(40)) i_eeprom_link_host (.clk(clk), .rst(rst), .link(link), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
    eeprom_link_device #(.WRITE_CYCLES_P(BUSY_CYC)) i_eeprom_link_device (.link_clk(link_clk), .rst(rst),
        .link(link), .select_pin_low(SEL[0]), .select_pin_mid(SEL[1]), .select_pin_high(SEL[2]),
        .supply_low(supply_low), .permanent_lower_lock(permanent_lower_lock),
        .resettable_lower_lock(resettable_lower_lock), .write_busy(write_busy), .addr_ptr(addr_ptr));
    eeprom_link_asserts #(.WRITE_CYCLES_P(BUSY_CYC)) i_checker (.clk(clk), .link_clk(link_clk), .rst(rst),
        .scl(link.scl), .sda(link.sda), .dev_sda_oe(link.dev_sda_oe), .write_busy(write_busy),
        .addr_ptr(addr_ptr), .supply_low(supply_low), .read(read), .write(write), .waitrequest(waitrequest));

    always #5 clk = ~clk;
    initial begin
        link_clk = 1'b0;
        #13;
        forever #40 link_clk = ~link_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // shared tasks
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task bus(input logic wr, input logic [1:0] a, input logic [31:0] d, output logic [31:0] q);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge clk);
    endtask : bus

    task op(input logic [4:0] c, input logic [7:0] tx, output logic [31:0] st);
        bus(1'b1, REG_TXDATA, {24'h0, tx}, st);
        bus(1'b1, REG_CMD, {27'h0, c}, st);
        st = 32'h1;
        while (st[STATUS_BUSY_BIT] !== 1'b0) bus(1'b0, REG_STATUS, 32'h0, st);
    endtask : op

    task ack(input logic [4:0] c, input logic [7:0] tx, input logic e);
        logic [31:0] st;
        op(c, tx, st);
        chk("ack", {7'h0, e}, {7'h0, st[STATUS_ACK_BIT]});
    endtask : ack

    task rd(input logic [4:0] c, input logic [7:0] e);
        logic [31:0] st;
        op(c, 8'h00, st);
        chk("rx data", e, st[STATUS_RX_LSB +: 8]);
    endtask : rd

    task seek(input logic [7:0] a);
        ack(CS | CW, CTLW, 1'b1);
        ack(CW, a, 1'b1);
        ack(CS | CW, CTLR, 1'b1);
    endtask : seek

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task t_reg;
        logic [31:0] q;
        bus(1'b1, REG_TXDATA, 32'h5a, q);
        bus(1'b0, REG_TXDATA, 32'h0, q);
        chk("txdata", 8'h5a, q[7:0]);
        bus(1'b1, 2'h3, 32'hff, q);
        bus(1'b0, 2'h3, 32'h0, q);
        chk("unmapped", 8'h00, q[7:0]);
    endtask : t_reg

    task t_select;
        for (int i = 0; i < 8; i++) ack(CS | CW | CP, {ARRAY_TYPE_ID, i[2:0], 1'b0}, i[2:0] == SEL);
        ack(CS | CW, {ARRAY_TYPE_ID, ~SEL, 1'b0}, 1'b0);
        ack(CW | CP, 8'h00, 1'b0);
        ack(CS | CW | CP, {4'h3, SEL, 1'b0}, 1'b0);
    endtask : t_select

    task t_write_poll;
        int n;
        logic [31:0] st;
        ack(CS | CW, CTLW, 1'b1);
        ack(CW, 8'hff, 1'b1);
        ack(CW, 8'ha1, 1'b1);
        ack(CW, 8'hb2, 1'b1);
        ack(CW | CP, 8'hc3, 1'b1);
        ack(CS | CW | CP, CTLW, 1'b0);
        chk("write busy", 8'h01, {7'h0, write_busy});
        n = 0;
        st = 32'h0;
        while (st[STATUS_ACK_BIT] !== 1'b1 && n < 8) begin
            op(CS | CW | CP, CTLW, st);
            n++;
        end
        chk("poll ack", 8'h01, {7'h0, st[STATUS_ACK_BIT]});
    endtask : t_write_poll

    task t_read;
        seek(8'hff);
        rd(CR, 8'ha1);
        rd(CR | CN | CP, 8'hb2);
        chk("sda drive", 8'h00, {7'h0, link.dev_sda_oe});
        ack(CS | CW, CTLR, 1'b1);
        rd(CR | CN | CP, 8'hc3);
        chk("pointer", 8'h02, addr_ptr);
    endtask : t_read

    task t_supply;
        supply_low <= 1'b1;
        ack(CS | CW, CTLW, 1'b1);
        ack(CW, 8'h01, 1'b1);
        ack(CW | CP, 8'h77, 1'b1);
        ack(CS | CW | CP, CTLW, 1'b1);
        supply_low <= 1'b0;
        seek(8'h01);
        rd(CR | CN | CP, 8'hc3);
    endtask : t_supply

    task t_protect;
        logic [2:0] cls [3];
        logic [8:0] exp;
        cls = '{SET_LOCK_SELECT, CLEAR_LOCK_SELECT, SEL};
        exp = 9'b111_011_000;
        for (int l = 0; l < 3; l++) begin
            resettable_lower_lock <= (l == 1);
            permanent_lower_lock <= (l == 2);
            repeat (40) @(posedge clk);
            for (int k = 0; k < 3; k++) ack(CS | CW | CP, {PROT_TYPE_ID, cls[k], 1'b1}, exp[8-3*l-k]);
        end
    endtask : t_protect

    ////////////////////////////////////////////////////////////////////////////////
    // run control
    task finish_test;
        if (bad_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (90000) @(posedge clk);
        bad_count++;
        finish_test;
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        address = 2'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        supply_low = 1'b0;
        permanent_lower_lock = 1'b0;
        resettable_lower_lock = 1'b0;
        bad_count = 0;
        checks = 0;
        repeat (32) @(posedge clk);
        rst <= 1'b0;
        repeat (40) @(posedge clk);
        t_reg;
        t_select;
        t_write_poll;
        t_read;
        t_supply;
        t_protect;
        finish_test;
    end
endmodule : test_eeprom_i2c_read_and_poll
